// ---- dv/rcco_checker.sv ----
// Assertions on the run clock override block ports.
// Assumes a bind onto rcco_top and a legacy register left at reset.
`timescale 1ns/1ps
`default_nettype none
module rcco_checker (
   input wire logic                    CORE_CLK,
   input wire logic                    RST_N,
   input wire logic [7:0]              REG_ADDR,
   input wire logic [31:0]             REG_WDATA,
   input wire logic                    REG_WR,
   input wire logic                    REG_RD,
   input wire logic [31:0]             REG_RDATA,
   input wire rcco_pkg::rcco_clk_cfg_t CLK_CFG
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   ////////////////////////////////////////////////////////////////
   sequence s_on; REG_WR && REG_ADDR == 8'h70 && REG_WDATA[31] ##1 !REG_WR; endsequence
   property p_rst; $rose(RST_N) && REG_RD && REG_ADDR == 8'h70 |=> REG_RDATA == 32'h0780_2800; endproperty
   a_rst: assert property (p_rst) else $error("reset value wrong");
   property p_div; s_on |=> CLK_CFG.pll_divide_by == {1'h0, $past(REG_WDATA[28:23], 2)} + 7'h01; endproperty
   a_div: assert property (p_div) else $error("divisor wrong");
   property p_max; REG_WR && REG_ADDR == 8'h70 && REG_WDATA[31] && REG_WDATA[28:23] == 6'h3F ##1 !REG_WR
      |=> CLK_CFG.pll_divide_by == 7'h40; endproperty
   a_max: assert property (p_max) else $error("top divisor wrong");
   property p_skip; s_on |=> CLK_CFG.pll_skip == $past(REG_WDATA[11], 2); endproperty
   a_skip: assert property (p_skip) else $error("skip wrong");
   property p_off; s_on |=> CLK_CFG.pll_power_off == $past(REG_WDATA[13], 2); endproperty
   a_off: assert property (p_off) else $error("power off wrong");
   property p_src; s_on |=> CLK_CFG.osc_source_select == $past(REG_WDATA[6:4], 2); endproperty
   a_src: assert property (p_src) else $error("source wrong");
   property p_leg; REG_WR && REG_ADDR == 8'h70 && !REG_WDATA[31] ##1 !REG_WR |=> CLK_CFG.pll_divide_by == 7'h10;
   endproperty
   a_leg: assert property (p_leg) else $error("legacy not used");
endmodule
`default_nettype wire

// ---- dv/test_rcco_top.sv ----
// Testbench for the run clock override block.
// Assumes the legacy register is never written, so it keeps its reset value.
`timescale 1ns/1ps
`default_nettype none
module test_rcco_top;
   logic        CORE_CLK = 1'b0;
   logic        RST_N = 1'b0;
   logic [7:0]  REG_ADDR = 8'h00;
   logic [31:0] REG_WDATA = 32'h0;
   logic        REG_WR = 1'b0;
   logic        REG_RD = 1'b0;
   logic [31:0] REG_RDATA;
   rcco_pkg::rcco_clk_cfg_t CLK_CFG;
   logic [2:0]  src [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
   int          err_total = 0;
   int          total_checks = 0;
   rcco_top i_rcco_top (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .CLK_CFG(CLK_CFG));
   ////////////////////////////////////////////////////////////////
   initial forever #2 CORE_CLK = ~CORE_CLK;
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   // One idle cycle after each write keeps the checker's settle window clean.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      REG_ADDR <= a; REG_WDATA <= d; REG_WR <= 1'b1;
      @(posedge CORE_CLK) REG_WR <= 1'b0;
      @(posedge CORE_CLK);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      REG_ADDR <= a; REG_RD <= 1'b1;
      @(posedge CORE_CLK) REG_RD <= 1'b0;
      #1 chk("rdata", e, REG_RDATA);
      @(posedge CORE_CLK);
      #1 chk("rdata_idle", 32'h0000_0000, REG_RDATA);
      @(posedge CORE_CLK);
   endtask
   // Returns on a rising edge so the next task drives right after that edge.
   task automatic cfg(input logic [11:0] e);
      #1 chk("clk_cfg", {20'h0, e}, {20'h0, CLK_CFG});
      @(posedge CORE_CLK);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      #100000 err_total++;
      report_and_stop();
   end
   initial begin
      repeat (16) @(posedge CORE_CLK);
      RST_N <= 1'b1;
      rd(8'h70, 32'h0780_2800);
      cfg({1'h1, 1'h1, 3'h0, 7'h10});
      $display("reset test done");
      foreach (src[i]) begin
         wr(8'h70, 32'h9F80_0000 | {25'h0, src[i], 4'h0});
         cfg({1'h0, 1'h0, src[i], 7'h40});
      end
      $display("source test done");
      wr(8'h70, 32'h8000_2800);
      cfg({1'h1, 1'h1, 3'h0, 7'h01});
      $display("divisor test done");
      wr(8'h70, 32'hFFFF_FFFF);
      rd(8'h70, 32'h9F80_2870);
      cfg({1'h1, 1'h1, 3'h7, 7'h40});
      rd(8'h04, 32'h0);
      $display("reserved test done");
      wr(8'h70, 32'h0);
      cfg({1'h1, 1'h1, 3'h0, 7'h10});
      $display("legacy test done");
      report_and_stop();
   end
endmodule
bind rcco_top rcco_checker i_rcco_checker (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .CLK_CFG(CLK_CFG));
`default_nettype wire

// ---- rtl/rcco_cfg_reg.sv ----
// Masked configuration register with a reset value.
// Assumes writes come from the core clock domain.
`timescale 1ns/1ps
`default_nettype none
module rcco_cfg_reg #(
   parameter logic [31:0] RESET_VAL  = 32'h0000_0000,
   parameter logic [31:0] WRITE_MASK = 32'hFFFF_FFFF
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        wr_en,
   input  wire logic [31:0] wr_data,
   output logic      [31:0] value
);
   logic [31:0] value_reg;
   logic [31:0] value_next;

   // Reserved bits never store write data, so they read as zero, or as RESET_VAL until the first write clears them.
   always_comb begin
      value_next = value_reg;
      if (wr_en) begin
         value_next = wr_data & WRITE_MASK;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         value_reg <= RESET_VAL;
      end else begin
         value_reg <= value_next;
      end
   end

   assign value = value_reg;
endmodule
`default_nettype wire

// ---- rtl/rcco_pkg.sv ----
// Package for the run clock configuration override block.
// Assumes a single core clock domain and a plain register port.
package rcco_pkg;
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 32;
   localparam logic [7:0]  EXT_CFG_ADDR    = 8'h70;
   localparam logic [7:0]  LEGACY_CFG_ADDR = 8'h60;
   localparam int          ENABLE_BIT      = 31;
   localparam int          DIV_HI          = 28;
   localparam int          DIV_LO          = 23;
   localparam int          PWR_OFF_BIT     = 13;
   localparam int          SKIP_BIT        = 11;
   localparam int          SRC_HI          = 6;
   localparam int          SRC_LO          = 4;
   localparam int          LEG_DIV_HI      = 26;
   localparam int          LEG_DIV_LO      = 23;
   localparam logic [5:0]  DIV_RESET       = 6'h0F;
   localparam logic [2:0]  SRC_RESET       = 3'h0;
   localparam logic [31:0] EXT_WRITE_MASK  = 32'h9F80_2870;
   localparam logic [31:0] LEG_WRITE_MASK  = 32'h0780_2870;
   localparam logic [31:0] LEG_RESET       = 32'h0780_2800;

   typedef enum logic [2:0] {
      SRC_MAIN     = 3'h0,
      SRC_INT      = 3'h1,
      SRC_INT_DIV4 = 3'h2,
      SRC_INT_30K  = 3'h3,
      SRC_EXT_32K  = 3'h7
   } rcco_src_t;

   typedef struct packed {
      logic       pll_skip;
      logic       pll_power_off;
      rcco_src_t  osc_source_select;
      logic [6:0] pll_divide_by;
   } rcco_clk_cfg_t;
endpackage

// ---- rtl/rcco_top.sv ----
// Run clock configuration with an extended override register.
// Assumes one clock; the register port is driven from the same domain.
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - With the enable bit set, divisor, skip, power-off and source come from the extended register.
// - The six-bit extended divisor picks the ratio that derives the system clock from the PLL.
// - The extended divisor resets to hexadecimal 0F.
// - An extended divisor of all ones divides the PLL output by sixty-four.
// - The skip bit routes the chosen oscillator straight through and resets to one.
// - The source select field chooses among five oscillators and resets to zero.
module rcco_top (
   input  wire logic                          CORE_CLK,
   input  wire logic                          RST_N,
   input  wire logic [rcco_pkg::ADDR_W-1:0]   REG_ADDR,
   input  wire logic [rcco_pkg::DATA_W-1:0]   REG_WDATA,
   input  wire logic                          REG_WR,
   input  wire logic                          REG_RD,
   output logic      [rcco_pkg::DATA_W-1:0]   REG_RDATA,
   output rcco_pkg::rcco_clk_cfg_t            CLK_CFG
);
   ////////////////////////////////////////////////////////////////////////////
   logic [31:0] ext_value;
   logic [31:0] leg_value;
   localparam logic [31:0] EXT_RESET = {1'b0, 2'b00, rcco_pkg::DIV_RESET, 9'h000, 1'b1, 1'b0,
                                        1'b1, 4'h0, rcco_pkg::SRC_RESET, 4'h0};

   rcco_cfg_reg #(
      .RESET_VAL  (EXT_RESET),
      .WRITE_MASK (rcco_pkg::EXT_WRITE_MASK)
   ) u_ext (
      .clk     (CORE_CLK),
      .rst_n   (RST_N),
      .wr_en   (REG_WR && REG_ADDR == rcco_pkg::EXT_CFG_ADDR),
      .wr_data (REG_WDATA),
      .value   (ext_value)
   );

   rcco_cfg_reg #(
      .RESET_VAL  (rcco_pkg::LEG_RESET),
      .WRITE_MASK (rcco_pkg::LEG_WRITE_MASK)
   ) u_leg (
      .clk     (CORE_CLK),
      .rst_n   (RST_N),
      .wr_en   (REG_WR && REG_ADDR == rcco_pkg::LEGACY_CFG_ADDR),
      .wr_data (REG_WDATA),
      .value   (leg_value)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Read data is registered; unmapped addresses read zero.
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;

   always_comb begin
      rdata_next = 32'h0000_0000;
      if (REG_RD && REG_ADDR == rcco_pkg::EXT_CFG_ADDR) begin
         rdata_next = ext_value;
      end else if (REG_RD && REG_ADDR == rcco_pkg::LEGACY_CFG_ADDR) begin
         rdata_next = leg_value;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         rdata_reg <= 32'h0000_0000;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign REG_RDATA = rdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Effective configuration, registered so the clock logic sees clean levels.
   rcco_pkg::rcco_clk_cfg_t cfg_reg;
   rcco_pkg::rcco_clk_cfg_t cfg_next;
   logic [2:0]              src_raw;

   always_comb begin
      if (ext_value[rcco_pkg::ENABLE_BIT]) begin
         cfg_next.pll_skip      = ext_value[rcco_pkg::SKIP_BIT];
         cfg_next.pll_power_off = ext_value[rcco_pkg::PWR_OFF_BIT];
         src_raw                = ext_value[rcco_pkg::SRC_HI:rcco_pkg::SRC_LO];
         // Divisor field N divides by N+1, so all ones gives sixty-four.
         cfg_next.pll_divide_by = {1'b0, ext_value[rcco_pkg::DIV_HI:rcco_pkg::DIV_LO]} + 7'h01;
      end else begin
         cfg_next.pll_skip      = leg_value[rcco_pkg::SKIP_BIT];
         cfg_next.pll_power_off = leg_value[rcco_pkg::PWR_OFF_BIT];
         src_raw                = leg_value[rcco_pkg::SRC_HI:rcco_pkg::SRC_LO];
         cfg_next.pll_divide_by = {3'h0, leg_value[rcco_pkg::LEG_DIV_HI:rcco_pkg::LEG_DIV_LO]} + 7'h01;
      end
      cfg_next.osc_source_select = rcco_pkg::rcco_src_t'(src_raw);
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         // Reset shows what the legacy register selects at reset, so no odd value leaks for one cycle.
         cfg_reg <= '{pll_skip: 1'b1, pll_power_off: 1'b1, osc_source_select: rcco_pkg::SRC_MAIN,
                      pll_divide_by: 7'h10};
      end else begin
         cfg_reg <= cfg_next;
      end
   end

   assign CLK_CFG = cfg_reg;
endmodule
`default_nettype wire
